//--- shared/cic_ctx_if.sv
`timescale 1ns/1ps
// Context save, restore and software access to the shadow file
interface cic_ctx_if;
	import cic_pkg::*;
	logic                 save;
	cic_ctx_type          live;
	logic                 wr;
	logic [CTX_IDX_W-1:0] wrIdx;
	logic [DATA_W-1:0]    wrData;
	cic_ctx_type          shadow;

	modport ctrl  (output save, live, wr, wrIdx, wrData, input shadow);
	modport store (input save, live, wr, wrIdx, wrData, output shadow);
endinterface : cic_ctx_if

//--- shared/cic_pkg.sv
package cic_pkg;

	// Widths
	localparam int ADDR_W    = 12;
	localparam int DATA_W    = 8;
	localparam int PC_W      = 15;
	localparam int CTX_N     = 8;
	localparam int CTX_IDX_W = 3;

	// Register byte addresses, bank in the upper five bits
	localparam logic [ADDR_W-1:0] ADDR_CTRL        = 12'h00b;
	localparam logic [ADDR_W-1:0] ADDR_PERIPH_ENABLE_REG1        = 12'h091;
	localparam logic [ADDR_W-1:0] ADDR_EDGE        = 12'h095;
	localparam logic [ADDR_W-1:0] ADDR_SHADOW_BASE = 12'hfe8;

	// Control register fields, then the edge register select bit
	localparam int BIT_GIE  = 7;
	localparam int BIT_PERIPHERAL_IRQ_ENABLE = 6;
	localparam int BIT_T0IE = 5;
	localparam int BIT_EXTE = 4;
	localparam int BIT_PCE  = 3;
	localparam int BIT_T0IF = 2;
	localparam int BIT_EXTF = 1;
	localparam int BIT_PCF  = 0;
	localparam int BIT_EDGE_SEL = 0;

	// Reset values
	localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
	localparam logic [DATA_W-1:0] PERIPH_ENABLE_REG1_RST = 8'h00;
	localparam logic              EDGE_RST = 1'b0;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

	// Saved status drops watchdog-expired and power-down bits
	localparam logic [DATA_W-1:0] STATUS_SAVE_MASK = 8'he7;
	localparam logic [PC_W-1:0]   VECTOR_ADDR      = 15'h0004;
	localparam logic [PC_W-1:0]   PC_RST           = 15'h0000;

	// Shadow entry order
	localparam int CTX_W      = 0;
	localparam int CTX_STATUS = 1;
	localparam int CTX_BSR    = 2;
	localparam int CTX_PC_HIGH_LATCH = 3;
	localparam int CTX_FSR0L  = 4;
	localparam int CTX_FSR0H  = 5;
	localparam int CTX_FSR1L  = 6;
	localparam int CTX_FSR1H  = 7;

	typedef logic [CTX_N-1:0][DATA_W-1:0] cic_ctx_type;

	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_ISR = 2'b10
	} cic_state_type;

endpackage : cic_pkg

//--- sim/cic_cpu_model.sv
`timescale 1ns/1ps
// Stand-in for the CPU sequencer that vectors and returns
module cic_cpu_model
	import cic_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              retReq,
	input  wire logic              pcLoad,
	input  wire logic              ctxRestore,
	input  wire logic [DATA_W-1:0] restoreW,
	output logic      [PC_W-1:0]   cpuPc,
	output logic                   return_from_irq,
	output logic      [DATA_W-1:0] liveW
);
	// Known start so the block never samples unknown context
	initial begin
		cpuPc = 15'h0100;
		return_from_irq = 1'b0;
		liveW = 8'h5a;
	end
	// Service code scribbles W, so a lost restore would show at once
	always @(posedge mclk) begin
		cpuPc <= pcLoad ? VECTOR_ADDR : cpuPc + 15'h0001;
		return_from_irq <= retReq;
		if (pcLoad)
			liveW <= ~liveW;
		else if (ctxRestore)
			liveW <= restoreW;
	end
endmodule : cic_cpu_model

//--- sim/cic_top_sva.sv
`timescale 1ns/1ps
// Watch on the sequencer side of the interrupt block
module cic_top_sva
	import cic_pkg::*;
(
	input wire logic              mclk,
	input wire logic              rst_n,
	input wire logic [PC_W-1:0]   cpuPc,
	input wire logic              return_from_irq,
	input wire logic [DATA_W-1:0] liveW,
	input wire logic              irqRequest,
	input wire logic              inService,
	input wire logic              flushPrefetch,
	input wire logic              stackPush,
	input wire logic [PC_W-1:0]   pushValue,
	input wire logic              pcLoad,
	input wire logic [PC_W-1:0]   pcLoadValue,
	input wire logic              stackPop,
	input wire logic              ctxRestore,
	input wire logic [DATA_W-1:0] restoreW,
	input wire logic [DATA_W-1:0] restoreStatus
);
	// Single domain
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Entry pulses come together and open service
	property p_entry; stackPush |-> flushPrefetch && pcLoad && $rose(inService); endproperty
	a_entry: assert property (p_entry) else $error("entry pulses split");
	property p_vector; pcLoad |-> pcLoadValue == VECTOR_ADDR; endproperty
	a_vector: assert property (p_vector) else $error("wrong vector");
	property p_retpc; stackPush |-> pushValue == $past(cpuPc); endproperty
	a_retpc: assert property (p_retpc) else $error("wrong return address");
	property p_save; stackPush |-> restoreW == $past(liveW); endproperty
	a_save: assert property (p_save) else $error("W not saved");
	property p_mask; restoreStatus[4:3] == 2'b00; endproperty
	a_mask: assert property (p_mask) else $error("status bits 4:3 kept");
	// Return acts only inside service
	property p_ret; inService && return_from_irq |=> stackPop && ctxRestore && !inService; endproperty
	a_ret: assert property (p_ret) else $error("return not taken");
	property p_stray; !inService && return_from_irq |=> !stackPop; endproperty
	a_stray: assert property (p_stray) else $error("stray return");
	property p_pop; stackPop |-> ctxRestore && $fell(inService); endproperty
	a_pop: assert property (p_pop) else $error("pop outside return");
	c_entry: cover property (stackPush);
	c_ret: cover property (stackPop);
	c_req: cover property (irqRequest && !inService);
endmodule : cic_top_sva
bind cic_top cic_top_sva u_sva (.mclk(mclk), .rst_n(rst_n), .cpuPc(cpuPc), .return_from_irq(return_from_irq),
	.liveW(liveW), .irqRequest(irqRequest), .inService(inService),
	.flushPrefetch(flushPrefetch), .stackPush(stackPush), .pushValue(pushValue),
	.pcLoad(pcLoad), .pcLoadValue(pcLoadValue), .stackPop(stackPop),
	.ctxRestore(ctxRestore), .restoreW(restoreW), .restoreStatus(restoreStatus));

//--- sim/test_core_interrupt_control.sv
`timescale 1ns/1ps
module test_core_interrupt_control;
	import cic_pkg::*;
	logic              mclk = 0, rst_n = 0, regWr = 0, regRd = 0, extPin = 0;
	logic              tmr0Ovf = 0, retReq = 0, return_from_irq, irqRequest, inService;
	logic              stackPush, stackPop, pcLoad, ctxRestore;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWrData = '0, portChangeFlags = '0, periphFlags = '0;
	logic [DATA_W-1:0] regRdData, liveW, restoreW, restoreStatus;
	logic [PC_W-1:0]   cpuPc;
	logic [15:0]       restoreFsr0;
	int                error_cnt = 0, checked = 0;
	// 10 MHz
	always #50 mclk = ~mclk;
	// Context with every status bit set, so the save mask shows
	cic_top u_dut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .extPin(extPin),
		.tmr0Ovf(tmr0Ovf), .portChangeFlags(portChangeFlags), .periphFlags(periphFlags),
		.cpuPc(cpuPc), .return_from_irq(return_from_irq), .liveW(liveW), .liveStatus(8'hff),
		.liveBsr(8'h1f), .livePclath(8'h07), .liveFsr0(16'h1234), .liveFsr1(16'h5678),
		.irqRequest(irqRequest), .inService(inService), .flushPrefetch(),
		.stackPush(stackPush), .pushValue(), .pcLoad(pcLoad), .pcLoadValue(),
		.stackPop(stackPop), .ctxRestore(ctxRestore), .restoreW(restoreW),
		.restoreStatus(restoreStatus), .restoreBsr(), .restorePclath(),
		.restoreFsr0(restoreFsr0), .restoreFsr1());
	cic_cpu_model u_cpu (.mclk(mclk), .retReq(retReq), .pcLoad(pcLoad),
		.ctxRestore(ctxRestore), .restoreW(restoreW), .cpuPc(cpuPc), .return_from_irq(return_from_irq),
		.liveW(liveW));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Leading edge wait keeps a strobe from being assigned twice in one step
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string n);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		@(negedge mclk);
		chk(n, e, regRdData);
		// Hand back on a rising edge so callers drive on it
		@(posedge mclk);
	endtask : rd
	// Bounded wait for service to open or close; request shows in the entry cycle
	task automatic svc(input logic e);
		for (int i = 0; i < 10; i++) begin
			@(negedge mclk);
			if (inService === e)
				break;
		end
		chk("inService", 8'(e), 8'(inService));
		if (e)
			chk("irqRequest", 8'h01, 8'(irqRequest));
		@(posedge mclk);
	endtask : svc
	task automatic ret;
		@(posedge mclk);
		retReq <= 1'b1;
		@(posedge mclk);
		retReq <= 1'b0;
		svc(1'b0);
	endtask : ret
	task automatic t_regs;
		rd(ADDR_CTRL, 8'h00, "ctrl");
		rd(ADDR_PERIPH_ENABLE_REG1, 8'h00, "periph_enable_reg1");
		rd(12'h123, 8'h00, "unmapped");
		wr(ADDR_PERIPH_ENABLE_REG1, 8'ha5);
		rd(ADDR_PERIPH_ENABLE_REG1, 8'ha5, "periph_enable_reg1");
		wr(ADDR_CTRL, 8'h7f);
		rd(ADDR_CTRL, 8'h7e, "ctrl");
		wr(ADDR_CTRL, 8'h00);
		$display("t_regs done");
	endtask : t_regs
	// Wrong edge first, then the selected one
	task automatic t_edge(input logic sel);
		// Park the pin under the old select so that move is the wrong edge
		extPin <= sel;
		repeat (4) @(posedge mclk);
		wr(ADDR_EDGE, {7'h00, sel});
		wr(ADDR_CTRL, 8'h00);
		extPin <= ~sel;
		repeat (5) @(posedge mclk);
		rd(ADDR_CTRL, 8'h00, "wrong edge");
		extPin <= sel;
		repeat (4) @(posedge mclk);
		rd(ADDR_CTRL, 8'h02, "ext flag");
		wr(ADDR_CTRL, 8'h00);
		$display("t_edge done");
	endtask : t_edge
	// One source pending under one gating setup
	task automatic t_src(input logic [7:0] c, pc, pf, pie, input logic hit);
		wr(ADDR_PERIPH_ENABLE_REG1, pie);
		portChangeFlags <= pc;
		periphFlags <= pf;
		wr(ADDR_CTRL, c);
		if (hit) begin
			svc(1'b1);
			rd(ADDR_CTRL, (c & 8'h7f) | {7'h00, pc != 8'h00}, "ctrl in service");
			portChangeFlags <= 8'h00;
			periphFlags <= 8'h00;
			wr(ADDR_CTRL, c & 8'h78);
			ret();
			rd(ADDR_CTRL, (c & 8'h78) | 8'h80, "ctrl after return");
		end else begin
			repeat (6) @(negedge mclk);
			chk("irqRequest", 8'h00, 8'(irqRequest));
			@(posedge mclk);
		end
		portChangeFlags <= 8'h00;
		periphFlags <= 8'h00;
		wr(ADDR_CTRL, 8'h00);
		$display("t_src done");
	endtask : t_src
	// Save on entry, software edit of a shadow, restore on return
	task automatic t_ctx;
		logic [7:0] w0;
		wr(ADDR_CTRL, 8'ha0);
		w0 = liveW;
		tmr0Ovf <= 1'b1;
		@(posedge mclk);
		tmr0Ovf <= 1'b0;
		svc(1'b1);
		chk("restoreW", w0, restoreW);
		chk("restoreStatus", 8'he7, restoreStatus);
		chk("fsr0 low", 8'h34, restoreFsr0[7:0]);
		chk("fsr0 high", 8'h12, restoreFsr0[15:8]);
		wr(ADDR_SHADOW_BASE, 8'h3c);
		rd(ADDR_SHADOW_BASE, 8'h3c, "shadow W");
		wr(ADDR_CTRL, 8'h20);
		ret();
		repeat (2) @(negedge mclk);
		chk("liveW", 8'h3c, liveW);
		$display("t_ctx done");
	endtask : t_ctx
	task automatic results;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results
	initial begin
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		t_regs();
		t_edge(1'b1);
		t_edge(1'b0);
		t_src(8'h24, 8'h00, 8'h00, 8'h00, 1'b0);
		t_src(8'ha4, 8'h00, 8'h00, 8'h00, 1'b1);
		t_src(8'h82, 8'h00, 8'h00, 8'h00, 1'b0);
		t_src(8'h92, 8'h00, 8'h00, 8'h00, 1'b1);
		t_src(8'h88, 8'h01, 8'h00, 8'h00, 1'b1);
		t_src(8'h80, 8'h00, 8'h04, 8'h04, 1'b0);
		t_src(8'hc0, 8'h00, 8'h04, 8'h00, 1'b0);
		t_src(8'hc0, 8'h00, 8'h04, 8'h04, 1'b1);
		t_ctx();
		results();
	end
	// Whole run is well under two thousand cycles
	initial begin
		#2000000;
		error_cnt++;
		results();
	end
endmodule : test_core_interrupt_control

//--- src/cic_shadow.sv
`timescale 1ns/1ps
module cic_shadow
	import cic_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	cic_ctx_if.store ctx
);

	typedef struct packed {
		cic_ctx_type regs;
	} cic_shadow_state_type;

	cic_shadow_state_type shadow_reg;
	cic_shadow_state_type shadow_next;

	// Save on entry beats a software write in the same cycle
	always_comb begin
		shadow_next = shadow_reg;
		for (int i = 0; i < CTX_N; i++) begin
			if (ctx.save) begin
				shadow_next.regs[i] = ctx.live[i];
			end else if (ctx.wr && (ctx.wrIdx == CTX_IDX_W'(i))) begin
				shadow_next.regs[i] = ctx.wrData;
			end
		end
		// Live TO/PD never travel through the shadow
		shadow_next.regs[CTX_STATUS] = shadow_next.regs[CTX_STATUS] & STATUS_SAVE_MASK;
	end

	// Shadow file
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			shadow_reg <= '0;
		end else begin
			shadow_reg <= shadow_next;
		end
	end

	assign ctx.shadow = shadow_reg.regs;

endmodule : cic_shadow

//--- src/cic_top.sv
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module cic_top
	import cic_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst_n,
	// Register port
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [DATA_W-1:0] regWrData,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [DATA_W-1:0] regRdData,
	// Event sources
	input  wire logic              extPin,
	input  wire logic              tmr0Ovf,
	input  wire logic [DATA_W-1:0] portChangeFlags,
	input  wire logic [DATA_W-1:0] periphFlags,
	// CPU sequencer
	input  wire logic [PC_W-1:0]   cpuPc,
	input  wire logic              return_from_irq,
	input  wire logic [DATA_W-1:0] liveW,
	input  wire logic [DATA_W-1:0] liveStatus,
	input  wire logic [DATA_W-1:0] liveBsr,
	input  wire logic [DATA_W-1:0] livePclath,
	input  wire logic [15:0]       liveFsr0,
	input  wire logic [15:0]       liveFsr1,
	output logic                   irqRequest,
	output logic                   inService,
	output logic                   flushPrefetch,
	output logic                   stackPush,
	output logic      [PC_W-1:0]   pushValue,
	output logic                   pcLoad,
	output logic      [PC_W-1:0]   pcLoadValue,
	output logic                   stackPop,
	output logic                   ctxRestore,
	output logic      [DATA_W-1:0] restoreW,
	output logic      [DATA_W-1:0] restoreStatus,
	output logic      [DATA_W-1:0] restoreBsr,
	output logic      [DATA_W-1:0] restorePclath,
	output logic      [15:0]       restoreFsr0,
	output logic      [15:0]       restoreFsr1
);

	typedef struct packed {
		cic_state_type     state;
		logic [DATA_W-1:0] ctrl;
		logic [DATA_W-1:0] periph_enable_reg1;
		logic              edgeSel;
		logic              sync1;
		logic              sync2;
		logic              pinPrev;
		logic              edgeSeen;
		logic              irqReq;
		logic              enter;
		logic              leave;
		logic [PC_W-1:0]   pushVal;
		logic [PC_W-1:0]   vecAddr;
		logic [DATA_W-1:0] rdData;
	} cic_top_state_type;

	cic_top_state_type top_reg;
	cic_top_state_type top_next;

	cic_ctx_if ctx ();

	logic wrCtrl;
	logic wrPie1;
	logic wrEdge;
	logic shadowHit;
	logic riseSeen;
	logic fallSeen;
	logic coreReq;
	logic periphReq;
	logic reqNow;

	// Address decode, one register per address
	assign wrCtrl    = regWr && (regAddr == ADDR_CTRL);
	assign wrPie1    = regWr && (regAddr == ADDR_PERIPH_ENABLE_REG1);
	assign wrEdge    = regWr && (regAddr == ADDR_EDGE);
	assign shadowHit = (regAddr[ADDR_W-1:CTX_IDX_W] == ADDR_SHADOW_BASE[ADDR_W-1:CTX_IDX_W]);

	// Edges are taken only from the second stage and its delayed copy
	assign riseSeen = top_reg.sync2 & ~top_reg.pinPrev;
	assign fallSeen = ~top_reg.sync2 & top_reg.pinPrev;

	// Each core flag gated by its own enable
	assign coreReq = (top_reg.ctrl[BIT_T0IE] & top_reg.ctrl[BIT_T0IF])
		| (top_reg.ctrl[BIT_EXTE] & top_reg.ctrl[BIT_EXTF])
		| (top_reg.ctrl[BIT_PCE] & top_reg.ctrl[BIT_PCF]);

	// Peripheral enables map bit for bit onto the peripheral flags
	assign periphReq = top_reg.ctrl[BIT_PERIPHERAL_IRQ_ENABLE] & (|(top_reg.periph_enable_reg1 & periphFlags));

	// Global enable gates both groups
	assign reqNow = top_reg.ctrl[BIT_GIE] & (coreReq | periphReq);

	// Context handed to the shadow file
	assign ctx.live[CTX_W]      = liveW;
	assign ctx.live[CTX_STATUS] = liveStatus;
	assign ctx.live[CTX_BSR]    = liveBsr;
	assign ctx.live[CTX_PC_HIGH_LATCH] = livePclath;
	assign ctx.live[CTX_FSR0L]  = liveFsr0[7:0];
	assign ctx.live[CTX_FSR0H]  = liveFsr0[15:8];
	assign ctx.live[CTX_FSR1L]  = liveFsr1[7:0];
	assign ctx.live[CTX_FSR1H]  = liveFsr1[15:8];

	// Save in the same edge that moves the sequencer into service
	assign ctx.save   = (top_reg.state == ST_RUN) && reqNow;
	assign ctx.wr     = regWr && shadowHit;
	assign ctx.wrIdx  = regAddr[CTX_IDX_W-1:0];
	assign ctx.wrData = regWrData;

	// Next state
	always_comb begin
		top_next = top_reg;

		// Two-stage synchroniser, then delayed copy for edge detect
		top_next.sync1   = extPin;
		top_next.sync2   = top_reg.sync1;
		top_next.pinPrev = top_reg.sync2;

		// Edge is registered, flag follows one cycle later
		top_next.edgeSeen = top_reg.edgeSel ? riseSeen : fallSeen;

		top_next.enter = 1'b0;
		top_next.leave = 1'b0;

		// Software writes; bit 0 of control is read-only
		if (wrCtrl) begin
			top_next.ctrl[DATA_W-1:1] = regWrData[DATA_W-1:1];
		end
		if (wrPie1) begin
			top_next.periph_enable_reg1 = regWrData;
		end
		if (wrEdge) begin
			top_next.edgeSel = regWrData[BIT_EDGE_SEL];
		end

		// Hardware sets come after the write so a set is never lost
		if (top_reg.edgeSeen) begin
			top_next.ctrl[BIT_EXTF] = 1'b1;
		end
		if (tmr0Ovf) begin
			top_next.ctrl[BIT_T0IF] = 1'b1;
		end

		// Mirror only; clears when software clears every port flag
		top_next.ctrl[BIT_PCF] = |portChangeFlags;

		// Sequencer; no nesting, so a request in service waits
		unique case (top_reg.state)
			ST_RUN: begin
				if (reqNow) begin
					top_next.state          = ST_ISR;
					top_next.enter          = 1'b1;
					top_next.ctrl[BIT_GIE]  = 1'b0;
					top_next.pushVal        = cpuPc;
					top_next.vecAddr        = VECTOR_ADDR;
				end
			end
			ST_ISR: begin
				if (return_from_irq) begin
					top_next.state         = ST_RUN;
					top_next.leave         = 1'b1;
					top_next.ctrl[BIT_GIE] = 1'b1;
				end
			end
			default: begin
				top_next.state = ST_RUN;
			end
		endcase

		top_next.irqReq = reqNow;

		// Read data stand one cycle after the strobe only
		top_next.rdData = ZERO_BYTE;
		if (regRd) begin
			if (regAddr == ADDR_CTRL) begin
				top_next.rdData = top_reg.ctrl;
			end else if (regAddr == ADDR_PERIPH_ENABLE_REG1) begin
				top_next.rdData = top_reg.periph_enable_reg1;
			end else if (regAddr == ADDR_EDGE) begin
				top_next.rdData = {7'h00, top_reg.edgeSel};
			end else if (shadowHit) begin
				top_next.rdData = ctx.shadow[regAddr[CTX_IDX_W-1:0]];
			end
		end
	end

	// State register; reset loads ST_RUN, everything else clears
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			top_reg.state    <= ST_RUN;
			top_reg.ctrl     <= CTRL_RST;
			top_reg.periph_enable_reg1     <= PERIPH_ENABLE_REG1_RST;
			top_reg.edgeSel  <= EDGE_RST;
			top_reg.sync1    <= 1'b0;
			top_reg.sync2    <= 1'b0;
			top_reg.pinPrev  <= 1'b0;
			top_reg.edgeSeen <= 1'b0;
			top_reg.irqReq   <= 1'b0;
			top_reg.enter    <= 1'b0;
			top_reg.leave    <= 1'b0;
			top_reg.pushVal  <= PC_RST;
			top_reg.vecAddr  <= PC_RST;
			top_reg.rdData   <= ZERO_BYTE;
		end else begin
			top_reg <= top_next;
		end
	end

	cic_shadow u_shadow (
		.mclk  (mclk),
		.rst_n (rst_n),
		.ctx   (ctx.store)
	);

	// Outputs straight from flops
	assign regRdData     = top_reg.rdData;
	assign irqRequest    = top_reg.irqReq;
	assign inService     = (top_reg.state == ST_ISR);
	assign flushPrefetch = top_reg.enter;
	assign stackPush     = top_reg.enter;
	assign pushValue     = top_reg.pushVal;
	assign pcLoad        = top_reg.enter;
	assign pcLoadValue   = top_reg.vecAddr;
	assign stackPop      = top_reg.leave;
	assign ctxRestore    = top_reg.leave;

	// Restore values are the shadow flops themselves
	assign restoreW      = ctx.shadow[CTX_W];
	assign restoreStatus = ctx.shadow[CTX_STATUS];
	assign restoreBsr    = ctx.shadow[CTX_BSR];
	assign restorePclath = ctx.shadow[CTX_PC_HIGH_LATCH];
	assign restoreFsr0   = {ctx.shadow[CTX_FSR0H], ctx.shadow[CTX_FSR0L]};
	assign restoreFsr1   = {ctx.shadow[CTX_FSR1H], ctx.shadow[CTX_FSR1L]};

endmodule : cic_top
